/* File: sofd_pkg.sv */
// Package for the secondary opcode field decoder: fields, codes, op enum
package sofd_pkg;

  // ==========================================================
  // Primary opcodes and field positions
  localparam logic [5:0] OP_SPECIAL = 6'h00;
  localparam logic [5:0] OP_SYS_COP = 6'h10;
  localparam logic [5:0] OP_FLT_COP = 6'h11;
  localparam logic [5:0] OP_THIRD_SPECIAL = 6'h1F;
  localparam logic [5:0] FN_SHR_IMM = 6'h02;
  localparam logic [5:0] FN_SHR_VAR = 6'h06;
  localparam logic [5:0] FN_COND_MOVE = 6'h01;
  localparam logic [5:0] FN_BIT_EXTRACT = 6'h00;
  localparam logic [5:0] FN_BYTE_SHUFFLE = 6'h20;
  localparam int ROT_IMM_BIT = 21;
  localparam int ROT_VAR_BIT = 6;
  localparam int INTCTL_BIT = 5;

  // ==========================================================
  // System coprocessor rs codes and operation subgroup functions
  localparam logic [4:0] RS_SHADOW_READ = 5'h0A;
  localparam logic [4:0] RS_INT_CTL_MOVE = 5'h0B;
  localparam logic [4:0] RS_SHADOW_WRITE = 5'h0E;
  localparam logic [5:0] SF_TLB_READ = 6'h01;
  localparam logic [5:0] SF_TLB_WRITE_IDX = 6'h02;
  localparam logic [5:0] SF_TLB_INV = 6'h03;
  localparam logic [5:0] SF_TLB_INV_FLUSH = 6'h04;
  localparam logic [5:0] SF_TLB_WRITE_RND = 6'h06;
  localparam logic [5:0] SF_TLB_PROBE = 6'h08;
  localparam logic [5:0] SF_EXC_RETURN = 6'h18;
  localparam logic [5:0] SF_DBG_RETURN = 6'h1F;
  localparam logic [5:0] SF_WAIT_EVENT = 6'h20;
  localparam logic [5:0] SF_MODULE_ROW2 = 6'h10;
  localparam logic [5:0] SF_MODULE_ROW5 = 6'h28;
  localparam logic [5:0] SF_MODULE_ROW7 = 6'h38;

  // ==========================================================
  // Floating formats
  localparam logic [4:0] FMT_DOUBLE = 5'h11;
  localparam logic [4:0] FMT_WORD = 5'h14;
  localparam logic [4:0] FMT_LONG = 5'h15;
  localparam logic [5:0] FF_CVT_SINGLE = 6'h20;
  localparam logic [5:0] FF_CVT_DOUBLE = 6'h21;
  localparam logic [5:0] FF_CVT_PAIRED = 6'h26;
  localparam logic [5:0] FF_COMPARE_BASE = 6'h00;

  // ==========================================================
  // Release levels
  localparam logic [2:0] REL_FIRST = 3'h1;
  localparam logic [2:0] REL_SIXTH = 3'h6;

  typedef enum logic [5:0] {
    SOFD_NONE, SOFD_SHR_IMM, SOFD_ROT_IMM, SOFD_SHR_VAR, SOFD_ROT_VAR,
    SOFD_BYTE_SHUFFLE, SOFD_BIT_EXTRACT, SOFD_SHADOW_READ,
    SOFD_SHADOW_WRITE, SOFD_INT_DISABLE, SOFD_INT_ENABLE,
    SOFD_TLB_READ, SOFD_TLB_WRITE_IDX, SOFD_TLB_INV, SOFD_TLB_INV_FLUSH,
    SOFD_TLB_WRITE_RND, SOFD_TLB_PROBE, SOFD_EXC_RETURN, SOFD_DBG_RETURN,
    SOFD_WAIT_EVENT, SOFD_MODULE_OP,
    SOFD_FD_ADD, SOFD_FD_SUB, SOFD_FD_MUL, SOFD_FD_DIV, SOFD_FD_SQRT,
    SOFD_FD_ABS, SOFD_FD_MOV, SOFD_FD_NEG,
    SOFD_FD_ROUND_L, SOFD_FD_TRUNC_L, SOFD_FD_CEIL_L, SOFD_FD_FLOOR_L,
    SOFD_FD_ROUND_W, SOFD_FD_TRUNC_W, SOFD_FD_CEIL_W, SOFD_FD_FLOOR_W,
    SOFD_FI_CVT_SINGLE, SOFD_FI_CVT_DOUBLE, SOFD_FI_CVT_PAIRED,
    SOFD_FP_COMPARE_NEW
  } sofd_op_e;

  typedef struct packed {
    logic [2:0] release_level;
    logic fp64_enable;
    logic debug_present;
    logic module_present;
    logic shuffle_strict;
  } sofd_cfg_s;

  typedef struct packed {
    logic valid;
    sofd_op_e op;
    logic reserved_exc;
    logic is_double_src;
    logic [4:0] compare_cond;
  } sofd_dec_s;

endpackage : sofd_pkg

/* File: sofd_decoder.sv */
// Secondary opcode field decoder, registered on the core clock
`timescale 1ns/1ps
module sofd_decoder (
  input wire logic clock,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire sofd_pkg::sofd_cfg_s cfg,
  output sofd_pkg::sofd_dec_s dec_q
);

  // ==========================================================
  // Field decode
  function automatic logic sofd_is_first(input logic [2:0] rel);
    return rel <= sofd_pkg::REL_FIRST;
  endfunction : sofd_is_first

  function automatic logic sofd_is_sixth(input logic [2:0] rel);
    return rel >= sofd_pkg::REL_SIXTH;
  endfunction : sofd_is_sixth

  logic [5:0] opcode;
  logic [4:0] rs_field;
  logic [4:0] shamt;
  logic [5:0] funct;
  logic first_rel;
  logic sixth_rel;
  sofd_pkg::sofd_dec_s dec_d;

  assign opcode = instr[31:26];
  assign rs_field = instr[25:21];
  assign shamt = instr[10:6];
  assign funct = instr[5:0];
  assign first_rel = sofd_is_first(cfg.release_level);
  assign sixth_rel = sofd_is_sixth(cfg.release_level);

  // ==========================================================
  // Next decode
  always_comb begin
    dec_d = '0;
    dec_d.valid = instr_valid;
    dec_d.op = sofd_pkg::SOFD_NONE;
    dec_d.reserved_exc = 1'b0;
    dec_d.is_double_src = 1'b0;
    dec_d.compare_cond = 5'h00;
    if (instr_valid) begin
      case (opcode)
        sofd_pkg::OP_SPECIAL: begin
          if (funct == sofd_pkg::FN_SHR_IMM) begin
            if (!first_rel && instr[sofd_pkg::ROT_IMM_BIT]) begin
              dec_d.op = sofd_pkg::SOFD_ROT_IMM;
            end else begin
              dec_d.op = sofd_pkg::SOFD_SHR_IMM;
            end
          end else if (funct == sofd_pkg::FN_SHR_VAR) begin
            if (!first_rel && instr[sofd_pkg::ROT_VAR_BIT]) begin
              dec_d.op = sofd_pkg::SOFD_ROT_VAR;
            end else begin
              dec_d.op = sofd_pkg::SOFD_SHR_VAR;
            end
          end else if (funct == sofd_pkg::FN_COND_MOVE && sixth_rel) begin
            dec_d.reserved_exc = 1'b1;
          end
        end
        sofd_pkg::OP_THIRD_SPECIAL: begin
          if (first_rel) begin
            dec_d.reserved_exc = 1'b1;
          end else if (funct == sofd_pkg::FN_BIT_EXTRACT) begin
            dec_d.op = sofd_pkg::SOFD_BIT_EXTRACT;
          end else if (funct == sofd_pkg::FN_BYTE_SHUFFLE) begin
            // Holes in the sparse shift-field map are optional traps
            case (shamt[4:3])
              2'b00, 2'b01, 2'b10, 2'b11: begin
                if (shamt[2:0] == 3'h0 || !cfg.shuffle_strict) begin
                  dec_d.op = sofd_pkg::SOFD_BYTE_SHUFFLE;
                end else begin
                  dec_d.reserved_exc = 1'b1;
                end
              end
              default: dec_d.reserved_exc = 1'b1;
            endcase
          end else begin
            dec_d.reserved_exc = 1'b1;
          end
        end
        sofd_pkg::OP_SYS_COP: begin
          if (rs_field[4]) begin
            case (funct)
              sofd_pkg::SF_TLB_READ: dec_d.op = sofd_pkg::SOFD_TLB_READ;
              sofd_pkg::SF_TLB_WRITE_IDX:
                dec_d.op = sofd_pkg::SOFD_TLB_WRITE_IDX;
              sofd_pkg::SF_TLB_INV: dec_d.op = sofd_pkg::SOFD_TLB_INV;
              sofd_pkg::SF_TLB_INV_FLUSH:
                dec_d.op = sofd_pkg::SOFD_TLB_INV_FLUSH;
              sofd_pkg::SF_TLB_WRITE_RND:
                dec_d.op = sofd_pkg::SOFD_TLB_WRITE_RND;
              sofd_pkg::SF_TLB_PROBE: dec_d.op = sofd_pkg::SOFD_TLB_PROBE;
              sofd_pkg::SF_EXC_RETURN:
                dec_d.op = sofd_pkg::SOFD_EXC_RETURN;
              sofd_pkg::SF_WAIT_EVENT: dec_d.op = sofd_pkg::SOFD_WAIT_EVENT;
              sofd_pkg::SF_DBG_RETURN: begin
                if (cfg.debug_present) begin
                  dec_d.op = sofd_pkg::SOFD_DBG_RETURN;
                end else begin
                  dec_d.reserved_exc = 1'b1;
                end
              end
              sofd_pkg::SF_MODULE_ROW2, sofd_pkg::SF_MODULE_ROW5,
              sofd_pkg::SF_MODULE_ROW7: begin
                if (cfg.module_present) begin
                  dec_d.op = sofd_pkg::SOFD_MODULE_OP;
                end else begin
                  dec_d.reserved_exc = 1'b1;
                end
              end
              default: dec_d.reserved_exc = 1'b1;
            endcase
          end else begin
            case (rs_field)
              sofd_pkg::RS_INT_CTL_MOVE: begin
                if (first_rel) begin
                  dec_d.reserved_exc = 1'b1;
                end else if (instr[sofd_pkg::INTCTL_BIT]) begin
                  dec_d.op = sofd_pkg::SOFD_INT_ENABLE;
                end else begin
                  dec_d.op = sofd_pkg::SOFD_INT_DISABLE;
                end
              end
              sofd_pkg::RS_SHADOW_READ: begin
                if (first_rel) begin
                  dec_d.reserved_exc = 1'b1;
                end else begin
                  dec_d.op = sofd_pkg::SOFD_SHADOW_READ;
                end
              end
              sofd_pkg::RS_SHADOW_WRITE: begin
                if (first_rel) begin
                  dec_d.reserved_exc = 1'b1;
                end else begin
                  dec_d.op = sofd_pkg::SOFD_SHADOW_WRITE;
                end
              end
              // Plain moves belong to another decoder
              default: dec_d.op = sofd_pkg::SOFD_NONE;
            endcase
          end
        end
        sofd_pkg::OP_FLT_COP: begin
          if (rs_field == sofd_pkg::FMT_DOUBLE) begin
            dec_d.is_double_src = 1'b1;
            if (funct[5:4] == 2'b00) begin
              // Rows 0 and 1 map in enum order
              dec_d.op = sofd_pkg::sofd_op_e'(
                6'(sofd_pkg::SOFD_FD_ADD) + {2'b00, funct[3:0]}
              );
            end else if (sixth_rel && funct == 6'h11) begin
              dec_d.reserved_exc = 1'b1;
            end
          end else if (sixth_rel && (rs_field == sofd_pkg::FMT_WORD ||
                                     rs_field == sofd_pkg::FMT_LONG)) begin
            // Word/long code points stand for single/double here
            if (funct[5] == 1'b0) begin
              dec_d.op = sofd_pkg::SOFD_FP_COMPARE_NEW;
              dec_d.is_double_src = rs_field[0];
              dec_d.compare_cond = funct[4:0];
            end else begin
              dec_d.reserved_exc = 1'b1;
            end
          end else if (rs_field == sofd_pkg::FMT_WORD ||
                       rs_field == sofd_pkg::FMT_LONG) begin
            if (rs_field == sofd_pkg::FMT_LONG && !cfg.fp64_enable) begin
              dec_d.reserved_exc = 1'b1;
            end else begin
              case (funct)
                sofd_pkg::FF_CVT_SINGLE:
                  dec_d.op = sofd_pkg::SOFD_FI_CVT_SINGLE;
                sofd_pkg::FF_CVT_DOUBLE:
                  dec_d.op = sofd_pkg::SOFD_FI_CVT_DOUBLE;
                sofd_pkg::FF_CVT_PAIRED:
                  dec_d.op = sofd_pkg::SOFD_FI_CVT_PAIRED;
                default: dec_d.reserved_exc = 1'b1;
              endcase
            end
          end
        end
        default: dec_d.op = sofd_pkg::SOFD_NONE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dec_q <= '0;
    end else begin
      dec_q <= dec_d;
    end
  end

  // ==========================================================
  // Checks
  third_first_a: assert property (@(posedge clock) disable iff (!resetn)
    instr_valid && opcode == sofd_pkg::OP_THIRD_SPECIAL && first_rel
    |=> dec_q.reserved_exc && dec_q.op == sofd_pkg::SOFD_NONE)
    else $error("third special not trapped in first release");

  rot_imm_sel_a: assert property (@(posedge clock) disable iff (!resetn)
    instr_valid && opcode == sofd_pkg::OP_SPECIAL
    && funct == sofd_pkg::FN_SHR_IMM && !first_rel
    |=> dec_q.op == ($past(instr[21]) ? sofd_pkg::SOFD_ROT_IMM
                                       : sofd_pkg::SOFD_SHR_IMM))
    else $error("immediate rotate select wrong");

  shr_imm_old_a: assert property (@(posedge clock) disable iff (!resetn)
    instr_valid && opcode == sofd_pkg::OP_SPECIAL
    && funct == sofd_pkg::FN_SHR_IMM && first_rel
    |=> dec_q.op == sofd_pkg::SOFD_SHR_IMM)
    else $error("first release immediate shift rotated");

  rot_var_sel_a: assert property (@(posedge clock) disable iff (!resetn)
    instr_valid && opcode == sofd_pkg::OP_SPECIAL
    && funct == sofd_pkg::FN_SHR_VAR
    |=> dec_q.op == (($past(instr[6]) && !$past(first_rel))
        ? sofd_pkg::SOFD_ROT_VAR : sofd_pkg::SOFD_SHR_VAR))
    else $error("variable rotate select wrong");

  int_ctl_a: assert property (@(posedge clock) disable iff (!resetn)
    instr_valid && opcode == sofd_pkg::OP_SYS_COP
    && rs_field == sofd_pkg::RS_INT_CTL_MOVE && !first_rel && instr[5]
    |=> dec_q.op == sofd_pkg::SOFD_INT_ENABLE)
    else $error("interrupt enable not decoded");

  dbg_ret_a: assert property (@(posedge clock) disable iff (!resetn)
    dec_q.op == sofd_pkg::SOFD_DBG_RETURN
    |-> $past(cfg.debug_present)
        && $past(funct) == sofd_pkg::SF_DBG_RETURN)
    else $error("debug return decoded without support");

  long_fp64_a: assert property (@(posedge clock) disable iff (!resetn)
    instr_valid && opcode == sofd_pkg::OP_FLT_COP && !sixth_rel
    && rs_field == sofd_pkg::FMT_LONG && !cfg.fp64_enable
    |=> dec_q.reserved_exc)
    else $error("long format accepted without fp64");

  cmp_new_a: assert property (@(posedge clock) disable iff (!resetn)
    dec_q.op == sofd_pkg::SOFD_FP_COMPARE_NEW
    |-> $past(sixth_rel) && dec_q.compare_cond == $past(funct[4:0]))
    else $error("new compare decoded outside sixth release");

  fd_row_a: assert property (@(posedge clock) disable iff (!resetn)
    instr_valid && opcode == sofd_pkg::OP_FLT_COP
    && rs_field == sofd_pkg::FMT_DOUBLE && funct == 6'h0F
    |=> dec_q.op == sofd_pkg::SOFD_FD_FLOOR_W)
    else $error("double function decode wrong");

endmodule : sofd_decoder

/* File: sofd_fetch_model.sv */
// Instruction fetch stage model that hands words to the decoder
`timescale 1ns/1ps
module sofd_fetch_model (
  input wire logic clock,
  output logic instr_valid,
  output logic [31:0] instr
);
  // ==========================================================
  // Word delivery
  initial begin
    instr_valid = 1'b0;
    instr = 32'h0;
  end

  // One word per call, launched off the sampling edge; afterwards the word
  // lines show the inverse, so a stale word never passes for a fresh one
  task automatic present(input logic [31:0] w);
    @(negedge clock);
    instr_valid = 1'b1;
    instr = w;
    @(negedge clock);
    instr_valid = 1'b0;
    instr = ~w;
  endtask : present
endmodule : sofd_fetch_model

/* File: secondary_opcode_field_decoder_tb.sv */
// Self-checking testbench for the secondary opcode field decoder
`timescale 1ns/1ps
module secondary_opcode_field_decoder_tb;
  logic clock;
  logic resetn;
  logic instr_valid;
  logic [31:0] instr;
  sofd_pkg::sofd_cfg_s cfg;
  sofd_pkg::sofd_dec_s dec_q;
  int err_total;
  int n_tests;

  sofd_decoder u_sofd_decoder (
    .clock(clock),
    .resetn(resetn),
    .instr_valid(instr_valid),
    .instr(instr),
    .cfg(cfg),
    .dec_q(dec_q)
  );

  sofd_fetch_model u_sofd_fetch_model (
    .clock(clock),
    .instr_valid(instr_valid),
    .instr(instr)
  );

  always #2 clock = ~clock;

  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Word builders and access tasks
  function automatic logic [31:0] sp(input logic [5:0] fn,
                                     input logic [4:0] rs,
                                     input logic [4:0] sa);
    return {sofd_pkg::OP_SPECIAL, rs, 10'h000, sa, fn};
  endfunction : sp

  function automatic logic [31:0] s3(input logic [5:0] fn,
                                     input logic [4:0] sa);
    return {sofd_pkg::OP_THIRD_SPECIAL, 15'h0000, sa, fn};
  endfunction : s3

  function automatic logic [31:0] c0(input logic [4:0] rs,
                                     input logic [5:0] fn);
    return {sofd_pkg::OP_SYS_COP, rs, 15'h0000, fn};
  endfunction : c0

  function automatic logic [31:0] fp(input logic [4:0] fmt,
                                     input logic [5:0] fn);
    return {sofd_pkg::OP_FLT_COP, fmt, 15'h0000, fn};
  endfunction : fp

  // Condition code and source width are only checked for compares
  task automatic dec(input logic [31:0] w, input sofd_pkg::sofd_op_e op,
                     input logic rsv = 1'b0, input logic [5:0] cmp = 6'h00);
    logic [15:0] mask;
    u_sofd_fetch_model.present(w);
    mask = (op == sofd_pkg::SOFD_FP_COMPARE_NEW) ? 16'h3FFF : 16'h3FC0;
    chk({2'h0, dec_q} & mask, {2'h0, 1'b1, op, rsv, cmp} & mask);
  endtask : dec

  task automatic setc(input logic [2:0] rel, input logic f64,
                      input logic dbg, input logic md);
    @(negedge clock);
    cfg = {rel, f64, dbg, md, 1'b1};
  endtask : setc

  // ==========================================================
  // Main sequence
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    cfg = {3'h2, 4'hF};
    err_total = 0;
    n_tests = 0;
    repeat (20) @(negedge clock);
    chk({2'h0, dec_q}, 16'h0000);
    resetn = 1'b1;

    setc(3'h2, 1'b1, 1'b1, 1'b1);
    dec(sp(sofd_pkg::FN_SHR_IMM, 5'h01, 5'h03),
        sofd_pkg::SOFD_ROT_IMM);
    dec(sp(sofd_pkg::FN_SHR_IMM, 5'h00, 5'h03),
        sofd_pkg::SOFD_SHR_IMM);
    dec(sp(sofd_pkg::FN_SHR_VAR, 5'h00, 5'h01),
        sofd_pkg::SOFD_ROT_VAR);
    dec(sp(sofd_pkg::FN_SHR_VAR, 5'h00, 5'h00),
        sofd_pkg::SOFD_SHR_VAR);
    dec(s3(sofd_pkg::FN_BIT_EXTRACT, 5'h00),
        sofd_pkg::SOFD_BIT_EXTRACT);
    dec(s3(6'h01, 5'h00), sofd_pkg::SOFD_NONE, 1'b1);
    dec(s3(sofd_pkg::FN_BYTE_SHUFFLE, 5'h10),
        sofd_pkg::SOFD_BYTE_SHUFFLE);
    dec(s3(sofd_pkg::FN_BYTE_SHUFFLE, 5'h13),
        sofd_pkg::SOFD_NONE, 1'b1);
    // Lenient mode lets the shuffle holes through as plain shuffles
    @(negedge clock);
    cfg.shuffle_strict = 1'b0;
    dec(s3(sofd_pkg::FN_BYTE_SHUFFLE, 5'h13),
        sofd_pkg::SOFD_BYTE_SHUFFLE);
    setc(3'h2, 1'b1, 1'b1, 1'b1);
    dec(c0(sofd_pkg::RS_INT_CTL_MOVE, 6'h00),
        sofd_pkg::SOFD_INT_DISABLE);
    dec(c0(sofd_pkg::RS_INT_CTL_MOVE, 6'h20),
        sofd_pkg::SOFD_INT_ENABLE);
    dec(c0(sofd_pkg::RS_SHADOW_READ, 6'h00),
        sofd_pkg::SOFD_SHADOW_READ);
    dec(c0(sofd_pkg::RS_SHADOW_WRITE, 6'h00),
        sofd_pkg::SOFD_SHADOW_WRITE);
    @(negedge clock);
    chk({15'h0000, dec_q.valid}, 16'h0000);
    $display("Test release two shifts and moves done");

    setc(3'h1, 1'b1, 1'b1, 1'b1);
    dec(sp(sofd_pkg::FN_SHR_IMM, 5'h01, 5'h03),
        sofd_pkg::SOFD_SHR_IMM);
    dec(sp(sofd_pkg::FN_SHR_VAR, 5'h00, 5'h01),
        sofd_pkg::SOFD_SHR_VAR);
    for (int i = 0; i < 6; i++) begin
      dec(s3(6'h01 << i, 5'h00), sofd_pkg::SOFD_NONE, 1'b1);
    end
    dec(s3(sofd_pkg::FN_BIT_EXTRACT, 5'h00),
        sofd_pkg::SOFD_NONE, 1'b1);
    dec(c0(sofd_pkg::RS_INT_CTL_MOVE, 6'h20),
        sofd_pkg::SOFD_NONE, 1'b1);
    dec(c0(sofd_pkg::RS_SHADOW_READ, 6'h00),
        sofd_pkg::SOFD_NONE, 1'b1);
    dec(c0(sofd_pkg::RS_SHADOW_WRITE, 6'h00),
        sofd_pkg::SOFD_NONE, 1'b1);
    $display("Test first release done");

    setc(3'h2, 1'b1, 1'b1, 1'b1);
    dec(c0(5'h10, 6'h01), sofd_pkg::SOFD_TLB_READ);
    dec(c0(5'h10, 6'h02), sofd_pkg::SOFD_TLB_WRITE_IDX);
    dec(c0(5'h10, 6'h03), sofd_pkg::SOFD_TLB_INV);
    dec(c0(5'h10, 6'h04), sofd_pkg::SOFD_TLB_INV_FLUSH);
    dec(c0(5'h10, 6'h06), sofd_pkg::SOFD_TLB_WRITE_RND);
    dec(c0(5'h10, 6'h08), sofd_pkg::SOFD_TLB_PROBE);
    dec(c0(5'h10, 6'h18), sofd_pkg::SOFD_EXC_RETURN);
    dec(c0(5'h10, 6'h1F), sofd_pkg::SOFD_DBG_RETURN);
    dec(c0(5'h10, 6'h20), sofd_pkg::SOFD_WAIT_EVENT);
    dec(c0(5'h10, 6'h10), sofd_pkg::SOFD_MODULE_OP);
    dec(c0(5'h10, 6'h05), sofd_pkg::SOFD_NONE, 1'b1);
    dec(c0(5'h10, 6'h30), sofd_pkg::SOFD_NONE, 1'b1);
    setc(3'h2, 1'b1, 1'b0, 1'b0);
    dec(c0(5'h10, 6'h1F), sofd_pkg::SOFD_NONE, 1'b1);
    dec(c0(5'h10, 6'h28), sofd_pkg::SOFD_NONE, 1'b1);
    dec(c0(5'h10, 6'h18), sofd_pkg::SOFD_EXC_RETURN);
    $display("Test system operation group done");

    setc(3'h2, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 16; i++) begin
      dec(fp(sofd_pkg::FMT_DOUBLE, 6'(i)),
          sofd_pkg::sofd_op_e'(int'(sofd_pkg::SOFD_FD_ADD) + i));
    end
    dec(fp(sofd_pkg::FMT_WORD, 6'h20),
        sofd_pkg::SOFD_FI_CVT_SINGLE);
    dec(fp(sofd_pkg::FMT_WORD, 6'h21),
        sofd_pkg::SOFD_FI_CVT_DOUBLE);
    dec(fp(sofd_pkg::FMT_WORD, 6'h26),
        sofd_pkg::SOFD_FI_CVT_PAIRED);
    dec(fp(sofd_pkg::FMT_WORD, 6'h22),
        sofd_pkg::SOFD_NONE, 1'b1);
    dec(fp(sofd_pkg::FMT_LONG, 6'h28),
        sofd_pkg::SOFD_NONE, 1'b1);
    dec(fp(sofd_pkg::FMT_LONG, 6'h20),
        sofd_pkg::SOFD_FI_CVT_SINGLE);
    setc(3'h2, 1'b0, 1'b1, 1'b1);
    dec(fp(sofd_pkg::FMT_LONG, 6'h20),
        sofd_pkg::SOFD_NONE, 1'b1);
    $display("Test floating formats done");

    setc(3'h6, 1'b1, 1'b1, 1'b1);
    dec(fp(sofd_pkg::FMT_WORD, 6'h02), sofd_pkg::SOFD_FP_COMPARE_NEW, 1'b0,
        6'h02);
    dec(fp(sofd_pkg::FMT_LONG, 6'h13), sofd_pkg::SOFD_FP_COMPARE_NEW, 1'b0,
        6'h33);
    dec(fp(sofd_pkg::FMT_WORD, 6'h20),
        sofd_pkg::SOFD_NONE, 1'b1);
    dec(sp(sofd_pkg::FN_COND_MOVE, 5'h00, 5'h00),
        sofd_pkg::SOFD_NONE, 1'b1);
    dec(fp(sofd_pkg::FMT_DOUBLE, 6'h11),
        sofd_pkg::SOFD_NONE, 1'b1);
    $display("Test sixth release done");
    tally_and_finish();
  end

  // Whole run is under two hundred cycles; allow a wide margin
  initial begin
    #20000;
    err_total++;
    $display("BAD t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : secondary_opcode_field_decoder_tb
